// ### verilog/icsr_ctrl.v
// interrupt flags, enables, priorities, arbitration and control regs
//
// Behaviour
// R1: per-source sticky flag, set by event, sw clears
// R2: per-source software enable bit
// R3: per-source three-bit priority, eight levels
// R4: taken vector number and level latched readable
// R5: sources packed in natural bit order
// R6: status bits 7:5 hold low cpu level
// R7: upper level bit read-only to software
// R8: cpu level is upper bit plus three
// R9: upper level bit set blocks user requests
// R10: nesting disable makes level bits read-only
// R11: control one bit 15 nesting disable
// R12: control one holds trap flags, enables
// R13: control one bit 2 stack trap
// R14: bit 1 oscillator trap, bit 0 zero
// R15: control two bits 2:0 edge polarity
// R16: control two bit 15 alternate table
// R17: alternate table used for all vectors
// R18: equal level, lower vector number wins
// R19: request only above current cpu level
// R20: control two bit 14 timed disable status
`include "icsr_map.vh"

module icsr_ctrl #(
  parameter NSRC = 32,
  parameter EXT0_SRC = 0,
  parameter EXT1_SRC = 20,
  parameter EXT2_SRC = 29
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // peripheral request pulses, one per source
  input wire [NSRC-1:0] src_event,
  // external interrupt pins, asynchronous
  input wire [2:0] ext_pin,
  // trap cause pulses from the core
  input wire osc_fail_ev,
  input wire stack_err_ev,
  input wire addr_err_ev,
  input wire math_err_ev,
  input wire div0_ev,
  input wire shift_err_ev,
  input wire ova_ev,
  input wire ovb_ev,
  input wire cova_ev,
  input wire covb_ev,
  // core level control
  input wire trap_enter,
  input wire trap_exit,
  input wire timed_disable_active,
  input wire cpu_ack,
  // request to the cpu
  output reg irq_req_q,
  output reg [6:0] irq_vec_q,
  output reg [3:0] irq_lvl_q,
  output reg [23:0] vec_addr_q,
  // current state seen by the core
  output wire [3:0] cpu_priority_level,
  output wire alt_table_select,
  output wire acc_a_overflow_trap_en,
  output wire acc_b_overflow_trap_en,
  output wire catastrophic_trap_en
);

  localparam NFREG = (NSRC + 15) / 16;
  localparam NPREG = (NSRC + 3) / 4;

  ////////////////////////////////////////////////////////////////////////
  // state
  reg [NSRC-1:0] flag_q; // request_flag_regs
  reg [NSRC-1:0] flag_d;
  reg [NSRC-1:0] en_q; // source_enable_regs
  reg [NSRC-1:0] en_d;
  reg [2:0] prio_q [0:NSRC-1]; // source_priority_regs
  reg [2:0] prio_d [0:NSRC-1];
  reg [15:0] ctl1_q; // interrupt_control_one
  reg [15:0] ctl1_d;
  reg alt_q; // alt_table_select
  reg [2:0] pol_q; // ext2..0 edge polarity
  reg [2:0] lvl_lo_q; // low cpu level bits
  reg lvl_up_q; // cpu_priority_upper_bit
  reg [6:0] tvec_q; // taken_vector_number
  reg [3:0] tlvl_q; // taken_level
  reg [2:0] sy1_q; // pin sync stage one
  reg [2:0] sy2_q;
  reg [2:0] sy3_q;
  reg [2:0] pin_lvl_q; // filtered pin level
  reg [2:0] pin_lvl_d;
  reg [2:0] ext_edge; // qualified edge per pin
  reg [NSRC-1:0] set_ev; // all hardware set pulses
  // one loop variable per process, so none has two drivers
  integer i; // pin filter loop
  integer j; // per-source next-state loop
  integer k; // register update loop
  integer m; // arbitration loop
  integer n; // read mux loop

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire [5:0] widx = paddr[7:2];
  // write lands only at the completing access edge
  wire wr_en = psel & penable & pready & pwrite;
  wire setup = psel & ~penable;
  wire nest_dis = ctl1_q[`ICSR_NEST_BIT];

  // outputs from flops
  // R8: full level is upper bit over low bits
  assign cpu_priority_level = {lvl_up_q, lvl_lo_q};
  // R17: table select goes straight to fetch logic
  assign alt_table_select = alt_q;
  assign acc_a_overflow_trap_en = ctl1_q[`ICSR_OVA_TRAP_EN_BIT];
  assign acc_b_overflow_trap_en = ctl1_q[`ICSR_OVB_TRAP_EN_BIT];
  assign catastrophic_trap_en = ctl1_q[`ICSR_COV_TRAP_EN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // external pins: three flops, change counted when stages 2 and 3 agree
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
      sy3_q <= 3'h0;
      pin_lvl_q <= 3'h0;
    end else begin
      sy1_q <= ext_pin;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // filter and edge select
  always @* begin
    pin_lvl_d = pin_lvl_q;
    ext_edge = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (sy2_q[i] == sy3_q[i]) begin
        pin_lvl_d[i] = sy3_q[i];
      end
      // R15: polarity 1 falling, 0 rising
      if (pin_lvl_d[i] != pin_lvl_q[i]) begin
        ext_edge[i] = pol_q[i] ? ~pin_lvl_d[i] : pin_lvl_d[i];
      end
    end
  end

  // merge peripheral pulses with pin edges
  always @* begin
    set_ev = src_event;
    set_ev[EXT0_SRC] = src_event[EXT0_SRC] | ext_edge[0];
    set_ev[EXT1_SRC] = src_event[EXT1_SRC] | ext_edge[1];
    set_ev[EXT2_SRC] = src_event[EXT2_SRC] | ext_edge[2];
  end

  ////////////////////////////////////////////////////////////////////////
  // next state of per-source registers
  always @* begin
    flag_d = flag_q;
    en_d = en_q;
    for (j = 0; j < NSRC; j = j + 1) begin
      prio_d[j] = prio_q[j];
      // R5: source j at bit j mod 16 of word j/16
      if (wr_en && widx == `ICSR_FLAG_IDX + j / 16) begin
        flag_d[j] = pwdata[j % 16];
      end
      // R1: hardware set wins over a clearing write
      flag_d[j] = flag_d[j] | set_ev[j];
      // R2: individual enable
      if (wr_en && widx == `ICSR_EN_IDX + j / 16) begin
        en_d[j] = pwdata[j % 16];
      end
      // R3: three-bit level, four per word
      if (wr_en && widx == `ICSR_PRIO_IDX + j / 4) begin
        prio_d[j] = pwdata[(j % 4) * 4 +: 3];
      end
    end
  end

  // trap flags and enables
  always @* begin
    ctl1_d = ctl1_q;
    if (wr_en && widx == `ICSR_CTL1_IDX) begin
      // R11: nesting bit is plain read/write
      ctl1_d = pwdata[15:0] & `ICSR_CTL1_WMASK;
    end
    // R12: trap causes set, events beat clears
    ctl1_d[`ICSR_OVA_BIT] = ctl1_d[`ICSR_OVA_BIT] | ova_ev;
    ctl1_d[`ICSR_OVB_BIT] = ctl1_d[`ICSR_OVB_BIT] | ovb_ev;
    ctl1_d[`ICSR_COVA_BIT] = ctl1_d[`ICSR_COVA_BIT] | cova_ev;
    ctl1_d[`ICSR_COVB_BIT] = ctl1_d[`ICSR_COVB_BIT] | covb_ev;
    ctl1_d[`ICSR_SHIFT_BIT] = ctl1_d[`ICSR_SHIFT_BIT] | shift_err_ev;
    ctl1_d[`ICSR_DIV0_BIT] = ctl1_d[`ICSR_DIV0_BIT] | div0_ev;
    ctl1_d[`ICSR_MATH_BIT] = ctl1_d[`ICSR_MATH_BIT] | math_err_ev;
    ctl1_d[`ICSR_ADDR_BIT] = ctl1_d[`ICSR_ADDR_BIT] | addr_err_ev;
    // R13: stack trap flag
    ctl1_d[`ICSR_STK_BIT] = ctl1_d[`ICSR_STK_BIT] | stack_err_ev;
    // R14: oscillator trap flag, bit 0 held zero
    ctl1_d[`ICSR_OSC_BIT] = ctl1_d[`ICSR_OSC_BIT] | osc_fail_ev;
  end

  ////////////////////////////////////////////////////////////////////////
  // register update
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= {NSRC{1'b0}};
      en_q <= {NSRC{1'b0}};
      for (k = 0; k < NSRC; k = k + 1) begin
        prio_q[k] <= 3'h0;
      end
      ctl1_q <= `ICSR_RST16;
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      for (k = 0; k < NSRC; k = k + 1) begin
        prio_q[k] <= prio_d[k];
      end
      ctl1_q <= ctl1_d;
    end
  end

  // control two: table select and pin polarity
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alt_q <= 1'b0;
      pol_q <= 3'h0;
    end else if (wr_en && widx == `ICSR_CTL2_IDX) begin
      // R16: bit 15 table select
      alt_q <= pwdata[`ICSR_ALT_BIT];
      // R15: bits 2:0 polarity
      pol_q <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration: highest level above cpu, ties to lowest index
  reg [2:0] best_lvl;
  reg [6:0] best_idx;
  reg found;
  always @* begin
    best_lvl = 3'h0;
    best_idx = 7'h00;
    found = 1'b0;
    // walk down so an equal level at a lower index takes over
    for (m = NSRC - 1; m >= 0; m = m - 1) begin
      // R19: flag, enable and level above cpu
      // R9: upper bit set blocks everything
      if (flag_q[m] && en_q[m] && !lvl_up_q &&
          prio_q[m] > lvl_lo_q) begin
        // R18: equal level, lower index wins
        if (!found || prio_q[m] >= best_lvl) begin
          best_lvl = prio_q[m];
          best_idx = m[6:0];
          found = 1'b1;
        end
      end
    end
  end

  // registered request and vector toward the cpu
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 7'h00;
      irq_lvl_q <= 4'h0;
      vec_addr_q <= 24'h00_0000;
    end else begin
      irq_req_q <= found;
      irq_vec_q <= best_idx + `ICSR_VEC_BASE;
      irq_lvl_q <= {1'b0, best_lvl};
      // R17: alternate base for every vector
      vec_addr_q <= (alt_q ? `ICSR_AIVT_BASE : `ICSR_IVT_BASE) +
        {16'h0000, best_idx + `ICSR_VEC_BASE, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu level and taken vector
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lvl_lo_q <= 3'h0;
      tvec_q <= 7'h00;
      tlvl_q <= 4'h0;
    end else if (cpu_ack && irq_req_q) begin
      // R4: latch vector and its level on acceptance
      tvec_q <= irq_vec_q;
      tlvl_q <= irq_lvl_q;
      // no nesting: level forced to 7 while serviced
      lvl_lo_q <= nest_dis ? `ICSR_LVL_MAX : irq_lvl_q[2:0];
    end else if (wr_en && widx == `ICSR_STAT_IDX) begin
      // R10: writes ignored while nesting disabled
      if (!nest_dis) begin
        // R6: software sets low level bits
        lvl_lo_q <= pwdata[`ICSR_LVL_LO_LSB +: 3];
      end
    end
  end

  // upper level bit follows core trap entry and exit only
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lvl_up_q <= 1'b0;
    end else if (trap_enter) begin
      // R7: no bus path writes this bit
      lvl_up_q <= 1'b1;
    end else if (trap_exit) begin
      lvl_up_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and address check
  reg [15:0] rd_d;
  reg hit;
  always @* begin
    rd_d = 16'h0000;
    hit = 1'b1;
    if (widx < `ICSR_FLAG_IDX + NFREG) begin
      for (n = 0; n < NSRC; n = n + 1) begin
        if (widx == `ICSR_FLAG_IDX + n / 16) begin
          rd_d[n % 16] = flag_q[n];
        end
      end
    end else if (widx >= `ICSR_EN_IDX &&
                 widx < `ICSR_EN_IDX + NFREG) begin
      for (n = 0; n < NSRC; n = n + 1) begin
        if (widx == `ICSR_EN_IDX + n / 16) begin
          rd_d[n % 16] = en_q[n];
        end
      end
    end else if (widx >= `ICSR_PRIO_IDX &&
                 widx < `ICSR_PRIO_IDX + NPREG) begin
      for (n = 0; n < NSRC; n = n + 1) begin
        if (widx == `ICSR_PRIO_IDX + n / 4) begin
          rd_d[(n % 4) * 4 +: 3] = prio_q[n];
        end
      end
    end else if (widx == `ICSR_TAKEN_IDX) begin
      rd_d[`ICSR_TVEC_LSB +: 7] = tvec_q;
      rd_d[`ICSR_TLVL_LSB +: 4] = tlvl_q;
    end else if (widx == `ICSR_CTL1_IDX) begin
      rd_d = ctl1_q;
    end else if (widx == `ICSR_CTL2_IDX) begin
      rd_d[`ICSR_ALT_BIT] = alt_q;
      // R20: live timed-disable status, read only
      rd_d[`ICSR_TDIS_BIT] = timed_disable_active;
      rd_d[2:0] = pol_q;
    end else if (widx == `ICSR_STAT_IDX) begin
      rd_d[`ICSR_LVL_LO_LSB +: 3] = lvl_lo_q;
    end else if (widx == `ICSR_CORE_IDX) begin
      rd_d[`ICSR_LVL_UP_BIT] = lvl_up_q;
    end else begin
      // unmapped: zero data with error
      hit = 1'b0;
    end
  end

  // answer registered in setup, so access completes in one cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata <= {16'h0000, rd_d};
      end
    end
  end

endmodule

// ### verilog/icsr_map.vh
// register map and field constants for the interrupt control block
`ifndef ICSR_MAP_VH
`define ICSR_MAP_VH

// word indices (byte address = index * 4)
`define ICSR_FLAG_IDX 6'h00
`define ICSR_EN_IDX 6'h04
`define ICSR_PRIO_IDX 6'h08
`define ICSR_TAKEN_IDX 6'h18
`define ICSR_CTL1_IDX 6'h19
`define ICSR_CTL2_IDX 6'h1A
`define ICSR_STAT_IDX 6'h1B
`define ICSR_CORE_IDX 6'h1C

// interrupt_control_one fields
`define ICSR_NEST_BIT 15
`define ICSR_OVA_BIT 14
`define ICSR_OVB_BIT 13
`define ICSR_COVA_BIT 12
`define ICSR_COVB_BIT 11
`define ICSR_OVA_TRAP_EN_BIT 10
`define ICSR_OVB_TRAP_EN_BIT 9
`define ICSR_COV_TRAP_EN_BIT 8
`define ICSR_SHIFT_BIT 7
`define ICSR_DIV0_BIT 6
`define ICSR_MATH_BIT 4
`define ICSR_ADDR_BIT 3
`define ICSR_STK_BIT 2
`define ICSR_OSC_BIT 1
`define ICSR_CTL1_WMASK 16'hFFDE

// interrupt_control_two fields
`define ICSR_ALT_BIT 15
`define ICSR_TDIS_BIT 14

// cpu_status and core_control fields
`define ICSR_LVL_LO_LSB 5
`define ICSR_LVL_UP_BIT 3

// taken_vector_reg fields
`define ICSR_TVEC_LSB 0
`define ICSR_TLVL_LSB 8

// vector numbering and tables
`define ICSR_VEC_BASE 7'h08
`define ICSR_IVT_BASE 24'h00_0004
`define ICSR_AIVT_BASE 24'h00_0104
`define ICSR_LVL_MAX 3'h7

// reset values
`define ICSR_RST16 16'h0000

`endif

// ### verif/icsr_cpu.sv
// cpu core stand-in that takes requests after a set delay
module icsr_cpu (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // request in, delay, take out
  input wire irq_req_q,
  input wire [3:0] ack_lat,
  output logic cpu_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles the request has waited, saturating at 14
  logic [3:0] cnt_q;
  // a delay of 15 is never reached, so the request is never taken
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      cpu_ack <= 1'b0;
    end else begin
      cnt_q <= irq_req_q ? cnt_q + {3'h0, cnt_q != 4'hE} : 4'h0;
      cpu_ack <= irq_req_q && cnt_q == ack_lat;
    end
  end
endmodule

// ### verif/icsr_ctrl_assertions.sv
// port-level assertions for the interrupt control block
`include "icsr_map.vh"
module icsr_chk (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  // core side
  input wire trap_enter,
  input wire irq_req_q,
  input wire [6:0] irq_vec_q,
  input wire [3:0] irq_lvl_q,
  input wire [23:0] vec_addr_q,
  input wire [3:0] cpu_priority_level,
  input wire alt_table_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  rdy_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  lvl_above_a: assert property (
    irq_req_q |-> irq_lvl_q > $past(cpu_priority_level))
    else $error("request not above cpu level");
  upper_blk_a: assert property (
    $past(cpu_priority_level[3]) |-> !irq_req_q)
    else $error("request while upper level bit set");
  lvl_prio_a: assert property (
    irq_req_q |-> irq_lvl_q[3] == 1'b0 && irq_lvl_q != 4'h0)
    else $error("bad request level");
  vec_range_a: assert property (
    irq_req_q |-> irq_vec_q >= `ICSR_VEC_BASE && irq_vec_q < 7'h28)
    else $error("vector out of range");
  vec_addr_a: assert property (
    irq_req_q |-> vec_addr_q == ($past(alt_table_select) ?
    `ICSR_AIVT_BASE : `ICSR_IVT_BASE) + {16'h0000, irq_vec_q, 1'b0})
    else $error("vector address wrong");
  upper_trap_a: assert property (
    $rose(cpu_priority_level[3]) |-> $past(trap_enter))
    else $error("upper level bit rose without trap");
  ctl2_zero_a: assert property (
    pready && !pwrite && paddr[7:2] == `ICSR_CTL2_IDX
    |-> prdata[13:3] == 11'h000)
    else $error("reserved control two bits set");
endmodule
bind icsr_ctrl icsr_chk chk_u (.mclk, .nrst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .trap_enter, .irq_req_q, .irq_vec_q,
  .irq_lvl_q, .vec_addr_q, .cpu_priority_level, .alt_table_select);

// ### verif/icsr_ctrl_tb.sv
// self-checking bench for the interrupt control block
`include "icsr_map.vh"
module icsr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, cpu_ack, irq_req_q;
  logic trap_enter = 1'b0, trap_exit = 1'b0, timed_disable_active = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, src_event = '0;
  logic [2:0] ext_pin = '0;
  wire [2:0] trap_en;
  logic [9:0] trev = '0;
  logic [6:0] irq_vec_q;
  logic [3:0] irq_lvl_q, cpu_priority_level, ack_lat = 4'h0;
  logic [23:0] vec_addr_q;
  logic alt_table_select, rerr;
  logic [15:0] rdat;
  int miscompares = 0, checked = 0;
  // control one bit set by each trap pulse, in port order
  int pos[10] = '{1, 2, 3, 4, 6, 7, 14, 13, 12, 11};
  icsr_ctrl dut_u (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_event, .ext_pin,
    .osc_fail_ev(trev[0]), .stack_err_ev(trev[1]), .addr_err_ev(trev[2]),
    .math_err_ev(trev[3]), .div0_ev(trev[4]), .shift_err_ev(trev[5]),
    .ova_ev(trev[6]), .ovb_ev(trev[7]), .cova_ev(trev[8]),
    .covb_ev(trev[9]), .trap_enter, .trap_exit, .timed_disable_active,
    .cpu_ack, .irq_req_q, .irq_vec_q, .irq_lvl_q, .vec_addr_q,
    .cpu_priority_level, .alt_table_select,
    .acc_a_overflow_trap_en(trap_en[2]),
    .acc_b_overflow_trap_en(trap_en[1]),
    .catastrophic_trap_en(trap_en[0]));
  icsr_cpu cpu_u (.mclk, .nrst, .irq_req_q, .ack_lat, .cpu_ack);
  initial begin
    forever #2 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////
  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [5:0] i,
      input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata[15:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rdchk(input logic [5:0] i, input logic [15:0] e);
    xfer(1'b0, i, 16'h0000);
    chk(rdat, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic done(input string s);
    $display("test %s ended, %0d mismatches", s, miscompares);
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rdchk(`ICSR_STAT_IDX, 16'h0000);
    xfer(1'b0, 6'h3F, 16'h0000);
    chk(rerr, 1'b1);
    wr(`ICSR_CTL1_IDX, 16'hFFFF);
    rdchk(`ICSR_CTL1_IDX, 16'hFFDE);
    chk(trap_en, 3'h7);
    wr(`ICSR_CTL1_IDX, 16'h0000);
    timed_disable_active <= 1'b1;
    wr(`ICSR_CTL2_IDX, 16'hFFFF);
    rdchk(`ICSR_CTL2_IDX, 16'hC007);
    chk(alt_table_select, 1'b1);
    wr(`ICSR_CORE_IDX, 16'h0008);
    rdchk(`ICSR_CORE_IDX, 16'h0000);
    done("registers");
    for (int i = 0; i < 10; i++) begin
      trev <= 10'h001 << i;
      @(posedge mclk);
      trev <= '0;
      rdchk(`ICSR_CTL1_IDX, 16'h0001 << pos[i]);
      wr(`ICSR_CTL1_IDX, 16'h0000);
    end
    done("traps");
    // source 3 at level 4, taken at once by the core
    wr(`ICSR_CTL2_IDX, 16'h0000);
    wr(`ICSR_EN_IDX, 16'h0008);
    wr(`ICSR_PRIO_IDX, 16'h4000);
    src_event <= 32'h0000_0008;
    @(posedge mclk);
    src_event <= '0;
    cyc(8);
    rdchk(`ICSR_TAKEN_IDX, 16'h040B);
    rdchk(`ICSR_STAT_IDX, 16'h0080);
    chk(cpu_priority_level, 4'h4);
    rdchk(`ICSR_FLAG_IDX, 16'h0008);
    wr(`ICSR_FLAG_IDX, 16'h0000);
    rdchk(`ICSR_FLAG_IDX, 16'h0000);
    done("request");
    // sources 1 and 5 tie at level 2, core never takes them
    ack_lat <= 4'hF;
    wr(`ICSR_STAT_IDX, 16'h0000);
    wr(`ICSR_EN_IDX, 16'h0022);
    wr(`ICSR_PRIO_IDX, 16'h0020);
    wr(`ICSR_PRIO_IDX + 6'h01, 16'h0020);
    src_event <= 32'h0000_0022;
    @(posedge mclk);
    src_event <= '0;
    cyc(3);
    chk(irq_vec_q, 7'h09);
    chk(irq_lvl_q, 4'h2);
    chk(vec_addr_q, 24'h00_0016);
    wr(`ICSR_CTL2_IDX, 16'h8000);
    cyc(3);
    chk(vec_addr_q, 24'h00_0116);
    wr(`ICSR_STAT_IDX, 16'h0040);
    cyc(3);
    chk(irq_req_q, 1'b0);
    wr(`ICSR_STAT_IDX, 16'h0020);
    cyc(3);
    chk(irq_req_q, 1'b1);
    trap_enter <= 1'b1;
    @(posedge mclk);
    trap_enter <= 1'b0;
    cyc(3);
    chk(irq_req_q, 1'b0);
    chk(cpu_priority_level, 4'h9);
    wr(`ICSR_CORE_IDX, 16'h0000);
    rdchk(`ICSR_CORE_IDX, 16'h0008);
    trap_exit <= 1'b1;
    @(posedge mclk);
    trap_exit <= 1'b0;
    wr(`ICSR_CTL1_IDX, 16'h8000);
    rdchk(`ICSR_CTL1_IDX, 16'h8000);
    wr(`ICSR_STAT_IDX, 16'h0000);
    rdchk(`ICSR_STAT_IDX, 16'h0020);
    wr(`ICSR_CTL1_IDX, 16'h0000);
    chk(irq_req_q, 1'b1);
    wr(`ICSR_EN_IDX, 16'h0000);
    cyc(3);
    chk(irq_req_q, 1'b0);
    done("arbitration");
    // pins 0 and 2 on rising edges, pin 1 on falling edges
    wr(`ICSR_FLAG_IDX, 16'h0000);
    wr(`ICSR_CTL2_IDX, 16'h8002);
    ext_pin <= 3'h7;
    cyc(8);
    rdchk(`ICSR_FLAG_IDX, 16'h0001);
    rdchk(`ICSR_FLAG_IDX + 6'h01, 16'h2000);
    ext_pin <= 3'h0;
    cyc(8);
    rdchk(`ICSR_FLAG_IDX + 6'h01, 16'h2010);
    // pin 0 source at level 7, taken late by the core
    ack_lat <= 4'h3;
    wr(`ICSR_PRIO_IDX, 16'h0007);
    wr(`ICSR_STAT_IDX, 16'h0000);
    wr(`ICSR_EN_IDX, 16'h0001);
    cyc(10);
    rdchk(`ICSR_TAKEN_IDX, 16'h0708);
    rdchk(`ICSR_STAT_IDX, 16'h00E0);
    done("pins");
    results();
  end
  // watchdog, well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule
